// ### rtl/fcl_pkg.sv
// How it works
// - no-cache system: READ probe, data if dirty
// - FLUSH probe: supply dirty, invalidate, update lock
// - dup-tag system probes reads only on hits
// - flush with dup tags: data then invalidate
// - board cache dup tags filter probes; flush invalidates
// - device always looks up its own tags
// - lock register kept whenever duplicate tags exist
// - shared modify-intent fill forces WRITE BLOCK
// - SET DIRTY lost to conflict restarts write
// - INVALIDATE aborts write-back; restart becomes miss
// - other-block probe resumes same request
// - load-locked skips L1, sets lock, sends LOCK
// - lock flag cleared by writes, SC, refill
// - every fill but load-locked ANDs lock flag with system flag
// - no dup tags: system lock flag held high
// - store-conditional stops issue, drains write buffer
// - cached SC: invalidate L1, fail unlocked, write dirty
// - shared SC waits WRITE BLOCK acknowledge
// - noncached SC: WRITE BLOCK LOCK, fail input
// - lookup order: level one, secondary, board cache
// - system transfers start on sysclk edge, dack paced
// - read latency bits 7:4, write speed 11:8
package fcl_pkg;

  // ----------------------------------------------------------------
  // sizes and fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 4;
  localparam int LINES = 16;
  localparam int TAG_W = ADDR_W - IDX_W;
  localparam int CFG_W = 32;
  localparam int RD_LAT_LSB = 4;
  localparam int WR_SPD_LSB = 8;
  localparam int SPD_W = 4;
  localparam int SYSCLK_RATIO = 4;

  // ----------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PR_READ = 3'h0,
    PR_FLUSH = 3'h1,
    PR_INVALIDATE = 3'h2,
    PR_SET_SHARED = 3'h3,
    PR_READ_DIRTY_INV = 3'h4
  } fcl_probe_type;

  typedef enum logic [2:0] {
    RQ_READ_MISS = 3'h0,
    RQ_READ_MISS_MODIFY_INTENT = 3'h1,
    RQ_SET_DIRTY = 3'h2,
    RQ_WRITE_BLOCK = 3'h3,
    RQ_WRITE_BLOCK_LOCK = 3'h4,
    RQ_LOCK = 3'h5
  } fcl_req_type;

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_LOAD_LOCKED = 2'h2,
    OP_STORE_CONDITIONAL = 2'h3
  } fcl_op_type;

  function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
    return a[IDX_W-1:0];
  endfunction

  function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:IDX_W];
  endfunction

endpackage

// ### rtl/fcl_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fcl_link_if import fcl_pkg::*; ();
  logic sysclk_edge;
  logic probe_valid;
  fcl_probe_type probe_cmd;
  logic [ADDR_W-1:0] probe_addr;
  logic probe_ack;
  logic probe_data_valid;
  logic [DATA_W-1:0] probe_data;
  logic req_valid;
  fcl_req_type req_cmd;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_data;
  logic cack;
  logic cfail;
  logic fill;
  logic fill_shared;
  logic dack;
  logic [DATA_W-1:0] fill_data;
  logic system_lock_flag;

  modport device(
    input sysclk_edge, probe_valid, probe_cmd, probe_addr, cack, cfail,
    input fill, fill_shared, dack, fill_data, system_lock_flag,
    output probe_ack, probe_data_valid, probe_data,
    output req_valid, req_cmd, req_addr, req_data
  );

  modport host(
    output sysclk_edge, probe_valid, probe_cmd, probe_addr, cack, cfail,
    output fill, fill_shared, dack, fill_data, system_lock_flag,
    input probe_ack, probe_data_valid, probe_data,
    input req_valid, req_cmd, req_addr, req_data
  );
endinterface
`default_nettype wire

// ### rtl/fcl_wait_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fcl_wait_timer #(
  parameter int W = 4
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  output logic o_expired
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
    logic expired;
  } fcl_timer_type;

  fcl_timer_type st_r;
  fcl_timer_type st_nxt;

  // a zero count still waits one cycle
  always_comb begin
    st_nxt = st_r;
    // expired holds until reload, so a probe cycle cannot swallow it
    if (i_load) begin
      st_nxt.cnt = i_count;
      st_nxt.run = 1'b1;
      st_nxt.expired = 1'b0;
    end else if (st_r.run) begin
      if (st_r.cnt <= W'(1)) begin
        st_nxt.run = 1'b0;
        st_nxt.expired = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_expired = st_r.expired;
endmodule // fcl_wait_timer
`default_nettype wire

// ### rtl/fcl_device_end.sv
`timescale 1ns/1ps
`default_nettype none
module fcl_device_end import fcl_pkg::*; (
  input wire logic i_clock,
  input wire logic i_rst,
  fcl_link_if.device link,
  input wire logic i_op_valid,
  input wire fcl_op_type i_op,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_noncached,
  input wire logic i_bc_present,
  input wire logic [CFG_W-1:0] i_board_cache_config_reg,
  output logic o_busy,
  output logic o_done,
  output logic o_fail,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_lock_flag
);
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_IDLE,
    PH_L1,
    PH_L2,
    PH_BC,
    PH_WR,
    PH_SC_DRAIN,
    PH_REQ,
    PH_FILL
  } fcl_phase_type;

  typedef struct packed {
    logic valid;
    logic shared;
    logic dirty;
    logic in_l1;
    logic [TAG_W-1:0] tag;
    logic [DATA_W-1:0] data;
  } fcl_line_type;

  typedef struct packed {
    fcl_phase_type ph;
    fcl_line_type [LINES-1:0] line;
    fcl_op_type op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic nc;
    logic sc_lock;
    logic lock_flag;
    logic [ADDR_W-1:0] lock_addr;
    logic req_valid;
    fcl_req_type req_cmd;
    logic probe_ack;
    logic pdata_valid;
    logic [DATA_W-1:0] pdata;
    logic inv_pending;
    logic [IDX_W-1:0] inv_idx;
    logic busy;
    logic done;
    logic fail;
    logic [DATA_W-1:0] rdata;
  } fcl_dev_type;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic fcl_dev_type finish(input fcl_dev_type s, input logic failed);
    fcl_dev_type t;
    t = s;
    t.done = 1'b1;
    t.fail = failed;
    t.busy = 1'b0;
    t.ph = PH_IDLE;
    return t;
  endfunction

  // request waits in PH_REQ for the next sysclk edge
  function automatic fcl_dev_type issue(input fcl_dev_type s, input fcl_req_type c);
    fcl_dev_type t;
    t = s;
    t.req_cmd = c;
    t.req_valid = 1'b0;
    t.ph = PH_REQ;
    return t;
  endfunction

  function automatic fcl_req_type miss_of(input fcl_op_type o);
    return (o == OP_WRITE) ? RQ_READ_MISS_MODIFY_INTENT : RQ_READ_MISS;
  endfunction

  fcl_dev_type st_r;
  fcl_dev_type st_nxt;
  logic tmr_load;
  logic [SPD_W-1:0] tmr_count;
  logic tmr_expired;
  logic [IDX_W-1:0] ci;
  logic [IDX_W-1:0] pi;
  fcl_line_type cl;
  logic chit;
  logic phit;
  logic pwrite;

  fcl_wait_timer #(.W(SPD_W)) u_timer (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_load(tmr_load),
    .i_count(tmr_count),
    .o_expired(tmr_expired)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.fail = 1'b0;
    st_nxt.probe_ack = 1'b0;
    st_nxt.pdata_valid = 1'b0;
    tmr_load = 1'b0;
    tmr_count = i_board_cache_config_reg[RD_LAT_LSB +: SPD_W];
    ci = idx_of(st_r.addr);
    cl = st_r.line[ci];
    chit = cl.valid && (cl.tag == tag_of(st_r.addr));
    pi = idx_of(link.probe_addr);
    phit = st_r.line[pi].valid && (st_r.line[pi].tag == tag_of(link.probe_addr));
    pwrite = (link.probe_cmd != PR_READ) && (link.probe_cmd != PR_SET_SHARED);
    if (st_r.inv_pending) begin
      // invalidate one cycle after the dirty data left
      st_nxt.line[st_r.inv_idx].valid = 1'b0;
      st_nxt.line[st_r.inv_idx].dirty = 1'b0;
      st_nxt.inv_pending = 1'b0;
    end else if (link.probe_valid && !st_r.probe_ack) begin
      st_nxt.probe_ack = 1'b1;
      // tags always checked, so a partial duplicate store is enough
      if (phit && st_r.line[pi].dirty && link.probe_cmd != PR_INVALIDATE
          && link.probe_cmd != PR_SET_SHARED) begin
        st_nxt.pdata_valid = 1'b1;
        st_nxt.pdata = st_r.line[pi].data;
      end
      case (link.probe_cmd)
        PR_FLUSH, PR_READ_DIRTY_INV: begin
          if (phit) begin
            st_nxt.inv_pending = 1'b1;
            st_nxt.inv_idx = pi;
          end
        end
        PR_INVALIDATE: begin
          if (phit) begin
            st_nxt.line[pi].valid = 1'b0;
            st_nxt.line[pi].dirty = 1'b0;
          end
        end
        PR_SET_SHARED: begin
          if (phit) begin
            st_nxt.line[pi].shared = 1'b1;
          end
        end
        default: begin
        end
      endcase
      if (pwrite && link.probe_addr == st_r.lock_addr) begin
        st_nxt.lock_flag = 1'b0;
      end
      // same-block conflict drops a SET DIRTY or WRITE BLOCK request and rereads the tags;
      // another block leaves it standing
      if (st_r.ph == PH_REQ && pwrite && link.probe_addr == st_r.addr
          && (st_r.req_cmd == RQ_SET_DIRTY || st_r.req_cmd == RQ_WRITE_BLOCK)) begin
        st_nxt.req_valid = 1'b0;
        st_nxt.ph = PH_L2;
      end
    end else begin
      case (st_r.ph)
        PH_IDLE: begin
          if (i_op_valid) begin
            st_nxt.op = i_op;
            st_nxt.addr = i_addr;
            st_nxt.wdata = i_wdata;
            st_nxt.nc = i_noncached;
            st_nxt.busy = 1'b1;
            case (i_op)
              OP_LOAD_LOCKED: st_nxt.ph = PH_L2;
              OP_STORE_CONDITIONAL: st_nxt.ph = PH_SC_DRAIN;
              default: st_nxt.ph = PH_L1;
            endcase
          end
        end
        PH_L1: begin
          if (chit && cl.in_l1 && st_r.op == OP_READ) begin
            st_nxt.rdata = cl.data;
            st_nxt = finish(st_nxt, 1'b0);
          end else begin
            st_nxt.ph = PH_L2;
          end
        end
        PH_SC_DRAIN: begin
          // single unmerged write-buffer entry, flushed here
          st_nxt.line[ci].in_l1 = 1'b0;
          st_nxt.sc_lock = st_r.lock_flag;
          st_nxt.lock_flag = 1'b0;
          st_nxt.ph = PH_L2;
        end
        PH_L2: begin
          if (st_r.op == OP_STORE_CONDITIONAL && st_r.nc) begin
            st_nxt = issue(st_nxt, RQ_WRITE_BLOCK_LOCK);
          end else if (chit) begin
            case (st_r.op)
              OP_READ: begin
                st_nxt.line[ci].in_l1 = 1'b1;
                st_nxt.rdata = cl.data;
                st_nxt = finish(st_nxt, 1'b0);
              end
              OP_LOAD_LOCKED: begin
                st_nxt.rdata = cl.data;
                st_nxt.lock_addr = st_r.addr;
                st_nxt.lock_flag = 1'b1;
                st_nxt = issue(st_nxt, RQ_LOCK);
              end
              default: begin
                if (st_r.op == OP_STORE_CONDITIONAL && !st_r.sc_lock) begin
                  st_nxt = finish(st_nxt, 1'b1);
                end else if (cl.shared) begin
                  st_nxt = issue(st_nxt, RQ_WRITE_BLOCK);
                end else if (!cl.dirty) begin
                  st_nxt = issue(st_nxt, RQ_SET_DIRTY);
                end else begin
                  tmr_load = 1'b1;
                  tmr_count = i_board_cache_config_reg[WR_SPD_LSB +: SPD_W];
                  st_nxt.ph = PH_WR;
                end
              end
            endcase
          end else if (st_r.op == OP_STORE_CONDITIONAL) begin
            st_nxt = finish(st_nxt, 1'b1);
          end else if (i_bc_present) begin
            tmr_load = 1'b1;
            st_nxt.ph = PH_BC;
          end else begin
            st_nxt = issue(st_nxt, miss_of(st_r.op));
          end
        end
        PH_BC: begin
          // board cache tags sit outside; its lookup costs the read latency
          if (tmr_expired) begin
            st_nxt = issue(st_nxt, miss_of(st_r.op));
          end
        end
        PH_WR: begin
          if (tmr_expired) begin
            if (chit) begin
              st_nxt.line[ci].dirty = 1'b1;
              st_nxt.line[ci].data = st_r.wdata;
              st_nxt = finish(st_nxt, 1'b0);
            end else begin
              st_nxt.ph = PH_L2;
            end
          end
        end
        PH_REQ: begin
          if (!st_r.req_valid) begin
            st_nxt.req_valid = link.sysclk_edge;
          end else if (link.cack) begin
            st_nxt.req_valid = 1'b0;
            case (st_r.req_cmd)
              RQ_READ_MISS, RQ_READ_MISS_MODIFY_INTENT: st_nxt.ph = PH_FILL;
              RQ_LOCK: st_nxt = finish(st_nxt, 1'b0);
              RQ_WRITE_BLOCK_LOCK: st_nxt = finish(st_nxt, link.cfail);
              RQ_SET_DIRTY: begin
                st_nxt.line[ci].dirty = 1'b1;
                st_nxt.line[ci].data = st_r.wdata;
                st_nxt = finish(st_nxt, 1'b0);
              end
              default: begin
                st_nxt.line[ci].data = st_r.wdata;
                st_nxt = finish(st_nxt, 1'b0);
              end
            endcase
          end
        end
        PH_FILL: begin
          if (link.fill && link.dack) begin
            st_nxt.line[ci].valid = 1'b1;
            st_nxt.line[ci].shared = link.fill_shared;
            st_nxt.line[ci].dirty = 1'b0;
            st_nxt.line[ci].in_l1 = (st_r.op != OP_LOAD_LOCKED);
            st_nxt.line[ci].tag = tag_of(st_r.addr);
            st_nxt.line[ci].data = link.fill_data;
            st_nxt.lock_flag = st_r.lock_flag && link.system_lock_flag;
            st_nxt.rdata = link.fill_data;
            case (st_r.op)
              OP_LOAD_LOCKED: begin
                st_nxt.lock_addr = st_r.addr;
                st_nxt.lock_flag = 1'b1;
                st_nxt = issue(st_nxt, RQ_LOCK);
              end
              OP_WRITE: begin
                if (link.fill_shared) begin
                  st_nxt = issue(st_nxt, RQ_WRITE_BLOCK);
                end else begin
                  st_nxt.line[ci].dirty = 1'b1;
                  st_nxt.line[ci].data = st_r.wdata;
                  st_nxt = finish(st_nxt, 1'b0);
                end
              end
              default: st_nxt = finish(st_nxt, 1'b0);
            endcase
          end
        end
        default: st_nxt.ph = PH_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.probe_ack = st_r.probe_ack;
  assign link.probe_data_valid = st_r.pdata_valid;
  assign link.probe_data = st_r.pdata;
  assign link.req_valid = st_r.req_valid;
  assign link.req_cmd = st_r.req_cmd;
  assign link.req_addr = st_r.addr;
  assign link.req_data = st_r.wdata;
  assign o_busy = st_r.busy;
  assign o_done = st_r.done;
  assign o_fail = st_r.fail;
  assign o_rdata = st_r.rdata;
  assign o_lock_flag = st_r.lock_flag;
endmodule // fcl_device_end
`default_nettype wire

// ### rtl/fcl_host_end.sv
`timescale 1ns/1ps
`default_nettype none
module fcl_host_end import fcl_pkg::*; #(
  parameter int RATIO = SYSCLK_RATIO
) (
  input wire logic i_clock,
  input wire logic i_rst,
  fcl_link_if.host link,
  input wire logic i_dup_tags,
  input wire logic i_bus_valid,
  input wire logic i_bus_write,
  input wire logic [ADDR_W-1:0] i_bus_addr,
  input wire logic [DATA_W-1:0] i_fill_data,
  input wire logic i_fill_shared,
  output logic o_bus_busy,
  output logic o_wb_valid,
  output logic [ADDR_W-1:0] o_wb_addr,
  output logic [DATA_W-1:0] o_wb_data,
  output logic o_lock_valid
);
  localparam int CNT_W = $clog2(RATIO);

  typedef struct packed {
    logic [CNT_W-1:0] div;
    logic sys_edge;
    logic [LINES-1:0] dvalid;
    logic [LINES-1:0][TAG_W-1:0] dtag;
    logic lock_valid;
    logic [ADDR_W-1:0] lock_addr;
    logic probe_pend;
    logic probe_valid;
    fcl_probe_type probe_cmd;
    logic [ADDR_W-1:0] probe_addr;
    logic cack;
    logic cfail;
    logic fill_pend;
    logic fill;
    logic fill_shared;
    logic [DATA_W-1:0] fill_data;
    logic [ADDR_W-1:0] fill_addr;
    logic slf;
    logic bus_busy;
    logic wb_valid;
    logic [ADDR_W-1:0] wb_addr;
    logic [DATA_W-1:0] wb_data;
  } fcl_host_type;

  fcl_host_type st_r;
  fcl_host_type st_nxt;
  logic edge_now;
  logic dhit;
  logic lock_hit;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.cack = 1'b0;
    st_nxt.cfail = 1'b0;
    st_nxt.fill = 1'b0;
    st_nxt.wb_valid = 1'b0;
    edge_now = (st_r.div == CNT_W'(RATIO - 1));
    st_nxt.sys_edge = edge_now;
    st_nxt.div = edge_now ? '0 : st_r.div + CNT_W'(1);
    dhit = st_r.dvalid[idx_of(i_bus_addr)]
        && (st_r.dtag[idx_of(i_bus_addr)] == tag_of(i_bus_addr));
    lock_hit = st_r.lock_valid && (st_r.lock_addr == link.req_addr);
    // without a lock register the flag is simply held high
    st_nxt.slf = !i_dup_tags || st_r.lock_valid;
    // traffic of other bus nodes, filtered by duplicate tags if present
    if (i_bus_valid && !st_r.bus_busy) begin
      if (!i_dup_tags || dhit) begin
        st_nxt.probe_pend = 1'b1;
        st_nxt.bus_busy = 1'b1;
        st_nxt.probe_cmd = i_bus_write ? PR_FLUSH : PR_READ;
        st_nxt.probe_addr = i_bus_addr;
      end
      if (i_bus_write) begin
        if (dhit) begin
          st_nxt.dvalid[idx_of(i_bus_addr)] = 1'b0;
        end
        if (st_r.lock_addr == i_bus_addr) begin
          st_nxt.lock_valid = 1'b0;
        end
      end
    end
    // probes never share a cycle with cack or fill
    if (st_r.probe_valid) begin
      if (link.probe_ack) begin
        st_nxt.probe_valid = 1'b0;
        st_nxt.probe_pend = 1'b0;
        st_nxt.bus_busy = 1'b0;
        st_nxt.wb_valid = link.probe_data_valid;
        st_nxt.wb_addr = st_r.probe_addr;
        st_nxt.wb_data = link.probe_data;
      end
    end else if (st_r.probe_pend && edge_now && !st_r.cack && !st_r.fill) begin
      st_nxt.probe_valid = 1'b1;
    end
    if (link.req_valid && edge_now && !st_r.cack && !st_r.probe_pend && !st_r.fill_pend) begin
      st_nxt.cack = 1'b1;
      case (link.req_cmd)
        RQ_READ_MISS, RQ_READ_MISS_MODIFY_INTENT: begin
          st_nxt.fill_pend = 1'b1;
          st_nxt.fill_addr = link.req_addr;
        end
        RQ_LOCK: begin
          st_nxt.lock_valid = i_dup_tags;
          st_nxt.lock_addr = link.req_addr;
        end
        RQ_WRITE_BLOCK, RQ_WRITE_BLOCK_LOCK: begin
          st_nxt.cfail = (link.req_cmd == RQ_WRITE_BLOCK_LOCK) && i_dup_tags && !lock_hit;
          st_nxt.wb_valid = !st_nxt.cfail;
          st_nxt.wb_addr = link.req_addr;
          st_nxt.wb_data = link.req_data;
        end
        default: begin
        end
      endcase
    end
    // single-beat fill; i_fill_shared on a modify-intent miss costs a write-back
    if (st_r.fill_pend && edge_now && !st_r.cack && !st_r.probe_pend) begin
      st_nxt.fill = 1'b1;
      st_nxt.fill_pend = 1'b0;
      st_nxt.fill_data = i_fill_data;
      st_nxt.fill_shared = i_fill_shared;
      st_nxt.dvalid[idx_of(st_r.fill_addr)] = 1'b1;
      st_nxt.dtag[idx_of(st_r.fill_addr)] = tag_of(st_r.fill_addr);
    end
  end

  // ----------------------------------------------------------------
  // registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.sysclk_edge = st_r.sys_edge;
  assign link.probe_valid = st_r.probe_valid;
  assign link.probe_cmd = st_r.probe_cmd;
  assign link.probe_addr = st_r.probe_addr;
  assign link.cack = st_r.cack;
  assign link.cfail = st_r.cfail;
  assign link.fill = st_r.fill;
  assign link.dack = st_r.fill;
  assign link.fill_shared = st_r.fill_shared;
  assign link.fill_data = st_r.fill_data;
  assign link.system_lock_flag = st_r.slf;
  assign o_bus_busy = st_r.bus_busy;
  assign o_wb_valid = st_r.wb_valid;
  assign o_wb_addr = st_r.wb_addr;
  assign o_wb_data = st_r.wb_data;
  assign o_lock_valid = st_r.lock_valid;
endmodule // fcl_host_end
`default_nettype wire

// ### test/fcl_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fcl_link_chk import fcl_pkg::*; (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic sysclk_edge,
  input wire logic probe_valid,
  input wire logic probe_ack,
  input wire logic probe_data_valid,
  input wire logic req_valid,
  input wire fcl_req_type req_cmd,
  input wire logic cack,
  input wire logic cfail,
  input wire logic fill,
  input wire logic dack
);
  // ----
  // link rules
  // ----
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence s_ans; ##[1:2] probe_ack; endsequence
  sequence s_rel; req_valid ##1 !req_valid; endsequence
  property p_probe_ans; $rose(probe_valid) |-> s_ans; endproperty
  property p_probe_edge; $rose(probe_valid) |-> sysclk_edge; endproperty
  property p_data_ack; probe_data_valid |-> probe_ack; endproperty
  property p_ack_rel; probe_ack |=> !probe_ack && !probe_valid; endproperty
  property p_cack_edge; cack |-> sysclk_edge; endproperty
  property p_fill_pair; (fill || dack) |-> fill && dack && sysclk_edge; endproperty
  property p_cfail; cfail |-> cack && req_cmd == RQ_WRITE_BLOCK_LOCK; endproperty
  property p_req_rel; cack |-> s_rel; endproperty
  a_probe_ans: assert property (p_probe_ans) else $error("probe not acked");
  a_probe_edge: assert property (p_probe_edge) else $error("probe off edge");
  a_data_ack: assert property (p_data_ack) else $error("data without ack");
  a_ack_rel: assert property (p_ack_rel) else $error("ack not a pulse");
  a_cack_edge: assert property (p_cack_edge) else $error("cack off edge");
  a_fill_pair: assert property (p_fill_pair) else $error("fill and dack apart");
  a_cfail: assert property (p_cfail) else $error("stray cfail");
  a_req_rel: assert property (p_req_rel) else $error("request not released");
endmodule // fcl_link_chk
`default_nettype wire

// ### test/flush_coherency_lock_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module flush_coherency_lock_control_test import fcl_pkg::*;;
  logic i_clock, i_rst, op_v, nc, dup, bv, bw, busy, done, fail, lk, bbusy, wbv, wv, bc, fs, lv;
  fcl_op_type op;
  logic [ADDR_W-1:0] a, ba, wba, wadr;
  logic [DATA_W-1:0] wd, fd, rd, wbd, wdat;
  int errors, n_tests;
  fcl_link_if lnk();
  fcl_device_end i_fcl_device_end (.i_clock(i_clock), .i_rst(i_rst), .link(lnk.device),
    .i_op_valid(op_v), .i_op(op), .i_addr(a), .i_wdata(wd), .i_noncached(nc),
    .i_bc_present(bc), .i_board_cache_config_reg(32'h0000_0210), .o_busy(busy),
    .o_done(done), .o_fail(fail), .o_rdata(rd), .o_lock_flag(lk));
  fcl_host_end #(.RATIO(3)) i_fcl_host_end (.i_clock(i_clock), .i_rst(i_rst),
    .link(lnk.host), .i_dup_tags(dup), .i_bus_valid(bv), .i_bus_write(bw),
    .i_bus_addr(ba), .i_fill_data(fd), .i_fill_shared(fs), .o_bus_busy(bbusy),
    .o_wb_valid(wbv), .o_wb_addr(wba), .o_wb_data(wbd), .o_lock_valid(lv));
  fcl_link_chk i_fcl_link_chk (.i_clock(i_clock), .i_rst(i_rst),
    .sysclk_edge(lnk.sysclk_edge), .probe_valid(lnk.probe_valid), .probe_ack(lnk.probe_ack),
    .probe_data_valid(lnk.probe_data_valid), .req_valid(lnk.req_valid),
    .req_cmd(lnk.req_cmd), .cack(lnk.cack), .cfail(lnk.cfail), .fill(lnk.fill),
    .dack(lnk.dack));
  // ----
  // access tasks
  // ----
  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic go(input fcl_op_type o, input logic [7:0] ad, input logic [31:0] d,
                    input logic n);
    int k;
    @(negedge i_clock);
    op = o;
    a = ad;
    wd = d;
    nc = n;
    op_v = 1'b1;
    wdat = '0;
    for (k = 0; k < 50 && busy !== 1'b1; k++) @(posedge i_clock) #1;
    @(negedge i_clock);
    op_v = 1'b0;
    // system pacing makes the answer time open, so bound it loosely
    for (k = 0; k < 300 && done !== 1'b1; k++) begin
      @(posedge i_clock) #1;
      if (wbv === 1'b1) wdat = wbd;
    end
    chk({31'h0, done}, 32'h1);
  endtask
  task automatic bus(input logic w, input logic [7:0] ad);
    int k;
    @(negedge i_clock);
    bw = w;
    ba = ad;
    bv = 1'b1;
    wv = 1'b0;
    wdat = '0;
    @(negedge i_clock);
    bv = 1'b0;
    for (k = 0; k < 30; k++) begin
      @(posedge i_clock) #1;
      if (wbv === 1'b1) begin
        wv = 1'b1;
        wdat = wbd;
        wadr = wba;
      end
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  initial begin
    #200000;
    errors++;
    complete_run;
  end
  initial begin
    i_rst = 1'b1;
    {op_v, nc, dup, bv, bw, bc, fs} = 7'h00;
    op = OP_READ;
    {a, ba} = 16'h0000;
    {wd, fd, wv, wdat, errors, n_tests} = '0;
    repeat (12) @(negedge i_clock);
    i_rst = 1'b0;
    fd = 32'h1111_0000;
    go(OP_WRITE, 8'h15, 32'hdead_0015, 1'b0);
    go(OP_READ, 8'h15, '0, 1'b0);
    chk(rd, 32'hdead_0015);
    bus(1'b0, 8'h15);
    chk({31'h0, wv}, 32'h1);
    chk(wdat, 32'hdead_0015);
    chk({24'h0, wadr}, 32'h15);
    go(OP_WRITE, 8'h15, 32'hbeef_0015, 1'b0);
    bus(1'b1, 8'h15);
    chk(wdat, 32'hbeef_0015);
    @(negedge i_clock) fd = 32'h2222_0015;
    go(OP_READ, 8'h15, '0, 1'b0);
    chk(rd, 32'h2222_0015);
    $display("test probes done");
    go(OP_LOAD_LOCKED, 8'h22, '0, 1'b0);
    chk({31'h0, lk}, 32'h1);
    bus(1'b1, 8'h22);
    chk({31'h0, wv}, 32'h0);
    chk({31'h0, lk}, 32'h0);
    go(OP_STORE_CONDITIONAL, 8'h22, 32'h77, 1'b0);
    chk({31'h0, fail}, 32'h1);
    go(OP_LOAD_LOCKED, 8'h22, '0, 1'b0);
    chk({31'h0, lk}, 32'h1);
    go(OP_STORE_CONDITIONAL, 8'h22, 32'h77, 1'b0);
    chk({31'h0, fail}, 32'h0);
    chk({31'h0, lk}, 32'h0);
    go(OP_READ, 8'h22, '0, 1'b0);
    chk(rd, 32'h77);
    @(negedge i_clock) dup = 1'b1;
    go(OP_STORE_CONDITIONAL, 8'h40, 32'h40, 1'b1);
    chk({31'h0, fail}, 32'h1);
    go(OP_LOAD_LOCKED, 8'h40, '0, 1'b0);
    chk({31'h0, lv}, 32'h1);
    go(OP_STORE_CONDITIONAL, 8'h40, 32'h40, 1'b1);
    chk({31'h0, fail}, 32'h0);
    chk(wdat, 32'h40);
    bus(1'b0, 8'h22);
    chk(wdat, 32'h77);
    chk({31'h0, bbusy}, 32'h0);
    @(negedge i_clock) {bc, fs} = 2'h3;
    go(OP_READ, 8'h36, '0, 1'b0);
    chk(rd, 32'h2222_0015);
    go(OP_WRITE, 8'h33, 32'h3333, 1'b0);
    chk(wdat, 32'h3333);
    $display("test lock done");
    complete_run;
  end
endmodule // flush_coherency_lock_control_test
`default_nettype wire
